// [verilog/txs_defines.svh]
// Offsets, field positions, reset values and timing counts for the driver and switch block
`ifndef TXS_DEFINES_SVH
`define TXS_DEFINES_SVH
// Notes on behaviour
// - Serial engine framing at rates to 848 kBd
// - Driver pins carry carrier modulated by envelope
// - Carrier is crystal clock halved; inverse selectable (here driver a inverts only under forced full depth)
// - Driver output unspecified while RF disabled
// - Envelope high selects continuous-wave PMOS conductance
// - Envelope low selects modulation PMOS conductance
// - NMOS conductance from CW or modulation nibble
// - Driver b CW bit: CW conductance, carrier
// - One conductance setting shared by both drivers
// - Mode and select registers set rate, driver
// - Select registers govern digital/analog/aux routing
// - Aux routing uses three select fields
// - Aux output source 100b sends Miller signal
// - Receiver select 01 takes aux input signal
// - Aux output can show protocol test signals
`define TXS_OFS_DRV_CTL 12'h000
`define TXS_OFS_TX_MODE 12'h004
`define TXS_OFS_TX_SEL 12'h008
`define TXS_OFS_RX_SEL 12'h00c
`define TXS_OFS_CW_PMOS 12'h010
`define TXS_OFS_MOD_PMOS 12'h014
`define TXS_OFS_NMOS 12'h018
`define TXS_OFS_STATUS 12'h01c
`define TXS_DC_EN_A 0
`define TXS_DC_EN_B 1
`define TXS_DC_CW_B 2
`define TXS_DC_INV_OFF_A 3
`define TXS_DC_INV_ON_A 4
`define TXS_DC_INV_OFF_B 5
`define TXS_DC_INV_ON_B 6
`define TXS_TM_FORCE 0
`define TXS_TM_SPEED_LSB 4
`define TXS_TS_AUX_LSB 0
`define TXS_TS_DRV_LSB 4
`define TXS_RS_RX_LSB 6
`define TXS_NM_CW_LSB 0
`define TXS_NM_MOD_LSB 4
`define TXS_RST_DRV_CTL 8'h00
`define TXS_RST_TX_MODE 8'h00
`define TXS_RST_TX_SEL 8'h10
`define TXS_RST_RX_SEL 8'h80
`define TXS_RST_PMOS 6'h20
`define TXS_RST_NMOS 8'h88
`define TXS_CARRIER_DIV 2
`define TXS_BASE_RATE_KBD 106
`define TXS_MAX_RATE_KBD 848
`define TXS_CARRIER_PER_BIT 128
`define TXS_MAX_SPEED ($clog2(`TXS_MAX_RATE_KBD / `TXS_BASE_RATE_KBD))
`define TXS_BIT_CYC_BASE (`TXS_CARRIER_DIV * `TXS_CARRIER_PER_BIT)
`endif

// [verilog/txs_pkg.sv]
// Types shared by the driver and switch block
`default_nettype none
package txs_pkg;
    typedef struct packed {
        logic enable;
        logic cw;
        logic inv_on;
        logic inv_off;
    } txs_drv_ctl_t;
    typedef struct packed {
        logic pin;
        logic cw_sel;
    } txs_drv_out_t;
    typedef enum logic [3:0] {
        TXS_AUX_LOW = 4'h0,
        TXS_AUX_HIGH = 4'h1,
        TXS_AUX_ENV = 4'h2,
        TXS_AUX_TX_SERIAL = 4'h3,
        TXS_AUX_MILLER = 4'h4,
        TXS_AUX_RX_ANALOG = 4'h5,
        TXS_AUX_DECODER = 4'h6,
        TXS_AUX_IN_ECHO = 4'h7
    } txs_aux_src_t;
    typedef enum logic [1:0] {
        TXS_RX_LOW = 2'h0,
        TXS_RX_AUX_IN = 2'h1,
        TXS_RX_ANALOG = 2'h2,
        TXS_RX_ANALOG_ALT = 2'h3
    } txs_rx_in_t;
endpackage
`default_nettype wire

// [verilog/txs_drv.sv]
// One antenna driver: pin waveform and conductance choice
`timescale 1ns/1ns
`default_nettype none
module txs_drv
    import txs_pkg::*;
#(
    parameter bit FIRST = 1'b1
) (
    input wire logic carrier,
    input wire logic envelope,
    input wire logic force_full_depth_mod,
    input wire txs_drv_ctl_t ctl,
    output var txs_drv_out_t drv
);
    wire logic pulled_low;
    wire logic invert;
    wire logic wave;
    // CW driver ignores the envelope entirely
    assign pulled_low = force_full_depth_mod && !envelope && !ctl.cw;
    // First driver only inverts under forced full depth
    assign invert = ctl.inv_on && (force_full_depth_mod || !FIRST);
    assign wave = pulled_low ? 1'b0 : (carrier ^ invert);
    always_comb begin
        // Off state is a static level; any level is acceptable there
        drv.pin = ctl.enable ? wave : ctl.inv_off;
        drv.cw_sel = ctl.cw || envelope;
    end
endmodule
`default_nettype wire

// [verilog/txs_top.sv]
// Antenna driver control and serial signal switch with an AHB-Lite register slave
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "txs_defines.svh"
module txs_top
    import txs_pkg::*;
#(
    parameter int PW = 6,
    parameter int NW = 4
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic envelope,
    input wire logic tx_serial,
    input wire logic miller_tx,
    input wire logic rx_analog,
    input wire logic aux_serial_in,
    output logic antenna_drive_a,
    output logic antenna_drive_b,
    output logic [PW-1:0] pmos_array_setting_a,
    output logic [PW-1:0] pmos_array_setting_b,
    output logic [NW-1:0] nmos_array_setting_a,
    output logic [NW-1:0] nmos_array_setting_b,
    output logic aux_serial_out,
    output logic decoder_in,
    output logic tx_bit_strobe
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // Bus address phase capture
    logic [11:0] addr_q;
    logic wr_q;
    logic rd_q;
    wire logic take;
    assign take = hsel && htrans[1] && hready;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addr_q <= 12'h000;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            addr_q <= haddr[11:0];
            // Only whole-word writes are stored
            wr_q <= take && hwrite && (hsize == 3'h2);
            rd_q <= take && !hwrite;
        end
    end

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    // Register file
    logic [7:0] drv_ctl_q;
    logic [7:0] tx_mode_q;
    logic [7:0] tx_sel_q;
    logic [7:0] rx_sel_q;
    logic [PW-1:0] cw_pmos_q;
    logic [PW-1:0] mod_pmos_q;
    logic [2*NW-1:0] nmos_q;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            drv_ctl_q <= `TXS_RST_DRV_CTL;
            tx_mode_q <= `TXS_RST_TX_MODE;
            tx_sel_q <= `TXS_RST_TX_SEL;
            rx_sel_q <= `TXS_RST_RX_SEL;
            cw_pmos_q <= PW'(`TXS_RST_PMOS);
            mod_pmos_q <= PW'(`TXS_RST_PMOS);
            nmos_q <= (2*NW)'(`TXS_RST_NMOS);
        end else if (wr_q) begin
            if (hit(addr_q, `TXS_OFS_DRV_CTL)) drv_ctl_q <= hwdata[7:0];
            if (hit(addr_q, `TXS_OFS_TX_MODE)) tx_mode_q <= hwdata[7:0];
            if (hit(addr_q, `TXS_OFS_TX_SEL)) tx_sel_q <= hwdata[7:0];
            if (hit(addr_q, `TXS_OFS_RX_SEL)) rx_sel_q <= hwdata[7:0];
            if (hit(addr_q, `TXS_OFS_CW_PMOS)) cw_pmos_q <= hwdata[PW-1:0];
            if (hit(addr_q, `TXS_OFS_MOD_PMOS)) mod_pmos_q <= hwdata[PW-1:0];
            if (hit(addr_q, `TXS_OFS_NMOS)) nmos_q <= hwdata[2*NW-1:0];
        end
    end

    // Field decode
    wire logic force_full_depth_mod;
    wire logic [2:0] speed_field;
    wire logic [3:0] aux_out_source_sel;
    wire logic [1:0] driver_input_sel;
    wire logic [1:0] receiver_input_sel;
    wire logic [NW-1:0] nmos_cw_value;
    wire logic [NW-1:0] nmos_mod_value;
    assign force_full_depth_mod = tx_mode_q[`TXS_TM_FORCE];
    assign speed_field = tx_mode_q[`TXS_TM_SPEED_LSB +: 3];
    assign aux_out_source_sel = tx_sel_q[`TXS_TS_AUX_LSB +: 4];
    assign driver_input_sel = tx_sel_q[`TXS_TS_DRV_LSB +: 2];
    assign receiver_input_sel = rx_sel_q[`TXS_RS_RX_LSB +: 2];
    assign nmos_cw_value = nmos_q[`TXS_NM_CW_LSB +: NW];
    assign nmos_mod_value = nmos_q[`TXS_NM_MOD_LSB +: NW];

    // Carrier: reference clock halved
    logic carrier_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            carrier_q <= 1'b0;
        end else begin
            carrier_q <= !carrier_q;
        end
    end

    // The first edge after reset still sees the reset level on both sides
    carrier_toggle_a: assert property (!$past(srst) |-> carrier_q != $past(carrier_q))
        else $error("carrier does not toggle every cycle");

    // Envelope source for the modulator
    wire logic [3:0] drv_taps;
    wire logic env_eff;
    // 00 holds continuous wave, 01 internal encoder, 10 external pin
    assign drv_taps = {1'b1, aux_serial_in, envelope, 1'b1};
    assign env_eff = drv_taps[driver_input_sel];

    // Drivers; both read the same conductance registers
    txs_drv_ctl_t ctl_a;
    txs_drv_ctl_t ctl_b;
    txs_drv_out_t drv_a;
    txs_drv_out_t drv_b;
    assign ctl_a = '{enable: drv_ctl_q[`TXS_DC_EN_A], cw: 1'b0,
                     inv_on: drv_ctl_q[`TXS_DC_INV_ON_A],
                     inv_off: drv_ctl_q[`TXS_DC_INV_OFF_A]};
    assign ctl_b = '{enable: drv_ctl_q[`TXS_DC_EN_B], cw: drv_ctl_q[`TXS_DC_CW_B],
                     inv_on: drv_ctl_q[`TXS_DC_INV_ON_B],
                     inv_off: drv_ctl_q[`TXS_DC_INV_OFF_B]};

    txs_drv #(.FIRST(1'b1)) u_drv_a (
        .carrier(carrier_q),
        .envelope(env_eff),
        .force_full_depth_mod(force_full_depth_mod),
        .ctl(ctl_a),
        .drv(drv_a)
    );
    txs_drv #(.FIRST(1'b0)) u_drv_b (
        .carrier(carrier_q),
        .envelope(env_eff),
        .force_full_depth_mod(force_full_depth_mod),
        .ctl(ctl_b),
        .drv(drv_b)
    );

    wire logic [PW-1:0] pmos_a_d;
    wire logic [PW-1:0] pmos_b_d;
    wire logic [NW-1:0] nmos_a_d;
    wire logic [NW-1:0] nmos_b_d;
    assign pmos_a_d = drv_a.cw_sel ? cw_pmos_q : mod_pmos_q;
    assign pmos_b_d = drv_b.cw_sel ? cw_pmos_q : mod_pmos_q;
    assign nmos_a_d = drv_a.cw_sel ? nmos_cw_value : nmos_mod_value;
    assign nmos_b_d = drv_b.cw_sel ? nmos_cw_value : nmos_mod_value;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            antenna_drive_a <= 1'b0;
            antenna_drive_b <= 1'b0;
            pmos_array_setting_a <= '0;
            pmos_array_setting_b <= '0;
            nmos_array_setting_a <= '0;
            nmos_array_setting_b <= '0;
        end else begin
            antenna_drive_a <= drv_a.pin;
            antenna_drive_b <= drv_b.pin;
            pmos_array_setting_a <= pmos_a_d;
            pmos_array_setting_b <= pmos_b_d;
            nmos_array_setting_a <= nmos_a_d;
            nmos_array_setting_b <= nmos_b_d;
        end
    end

    force_low_a: assert property (
        ctl_a.enable && force_full_depth_mod && !env_eff |=> !antenna_drive_a)
        else $error("driver a not pulled low under forced full depth");
    cw_pmos_a: assert property (
        ctl_a.enable && env_eff |=> pmos_array_setting_a == $past(cw_pmos_q))
        else $error("driver a pmos not at continuous-wave value");
    mod_pmos_a: assert property (
        !env_eff && !ctl_b.cw |=> pmos_array_setting_b == $past(mod_pmos_q))
        else $error("driver b pmos not at modulation value");
    nmos_pick_a: assert property (
        !env_eff |=> nmos_array_setting_a == $past(nmos_q[`TXS_NM_MOD_LSB +: NW]))
        else $error("driver a nmos not at modulation nibble");
    cw_drive_a: assert property (
        ctl_b.enable && ctl_b.cw |=> antenna_drive_b == ($past(carrier_q) ^ $past(ctl_b.inv_on))
            && pmos_array_setting_b == $past(cw_pmos_q))
        else $error("driver b ignores its continuous-wave bit");
    plain_carrier_a: assert property (
        ctl_a.enable && !force_full_depth_mod |=> antenna_drive_a == $past(carrier_q))
        else $error("driver a not carrying the carrier");
    plain_b_a: assert property (
        ctl_b.enable && !force_full_depth_mod && !ctl_b.cw
            |=> antenna_drive_b == ($past(carrier_q) ^ $past(ctl_b.inv_on)))
        else $error("driver b not carrying carrier or its inverse");

    // Receive decoder input
    wire logic [3:0] rx_taps;
    assign rx_taps = {rx_analog, rx_analog, aux_serial_in, 1'b0};

    // Aux output observation and active antenna taps
    wire logic [7:0] aux_taps;
    wire logic aux_d;
    assign aux_taps = {aux_serial_in, decoder_in, rx_analog, miller_tx,
                       tx_serial, env_eff, 1'b1, 1'b0};
    // Codes above the top tap read low so stray settings stay quiet
    assign aux_d = aux_out_source_sel[3] ? 1'b0 : aux_taps[aux_out_source_sel[2:0]];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            decoder_in <= 1'b0;
            aux_serial_out <= 1'b0;
        end else begin
            decoder_in <= rx_taps[receiver_input_sel];
            aux_serial_out <= aux_d;
        end
    end

    miller_out_a: assert property (
        aux_out_source_sel == TXS_AUX_MILLER |=> aux_serial_out == $past(miller_tx))
        else $error("aux output does not carry the Miller signal");
    rx_aux_in_a: assert property (
        receiver_input_sel == TXS_RX_AUX_IN |=> decoder_in == $past(aux_serial_in))
        else $error("decoder not fed from the aux input");

    // Bit clock for the serial engine, 106 kBd scaled by powers of two
    wire logic [1:0] speed_eff;
    wire logic [8:0] bit_cyc;
    logic [8:0] bit_cnt_q;
    wire logic bit_end;
    // Speeds above the top rate clamp rather than wrap
    assign speed_eff = (speed_field > 3'(`TXS_MAX_SPEED)) ? 2'(`TXS_MAX_SPEED)
                                                         : speed_field[1:0];
    assign bit_cyc = 9'(`TXS_BIT_CYC_BASE) >> speed_eff;
    assign bit_end = (bit_cnt_q >= bit_cyc - 9'h001);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bit_cnt_q <= 9'h000;
            tx_bit_strobe <= 1'b0;
        end else begin
            bit_cnt_q <= bit_end ? 9'h000 : bit_cnt_q + 9'h001;
            tx_bit_strobe <= bit_end;
        end
    end

    bit_rate_a: assert property (
        tx_bit_strobe |=> !tx_bit_strobe [*8])
        else $error("bit strobe faster than the top rate allows");

    // Read side: zero wait state, word mux
    wire logic [31:0] status_w;
    wire logic [31:0] rd_mux;
    assign status_w = {26'h0, drv_b.cw_sel, drv_a.cw_sel, antenna_drive_b,
                       antenna_drive_a, decoder_in, env_eff};
    assign rd_mux = hit(addr_q, `TXS_OFS_DRV_CTL) ? {24'h0, drv_ctl_q} :
                    hit(addr_q, `TXS_OFS_TX_MODE) ? {24'h0, tx_mode_q} :
                    hit(addr_q, `TXS_OFS_TX_SEL) ? {24'h0, tx_sel_q} :
                    hit(addr_q, `TXS_OFS_RX_SEL) ? {24'h0, rx_sel_q} :
                    hit(addr_q, `TXS_OFS_CW_PMOS) ? 32'(cw_pmos_q) :
                    hit(addr_q, `TXS_OFS_MOD_PMOS) ? 32'(mod_pmos_q) :
                    hit(addr_q, `TXS_OFS_NMOS) ? 32'(nmos_q) :
                    hit(addr_q, `TXS_OFS_STATUS) ? status_w : 32'h0;
    assign hrdata = rd_q ? rd_mux : 32'h0;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule
`default_nettype wire

// [dv/txs_ant_model.sv]
// Active antenna partner: answers on the auxiliary input pin
`timescale 1ns/1ns
`default_nettype none
module txs_ant_model (
    input wire logic ref_clk,
    input wire logic aux_serial_out,
    input wire logic reply,
    input wire logic slow,
    output var logic aux_serial_in
);
    logic [3:0] dly_q = 4'h0;
    // Slow mode stands for a long external loop, four cycles late
    // While not replying, the circuit loops the transmit signal back
    always_ff @(posedge ref_clk) begin
        dly_q <= {dly_q[2:0], reply | aux_serial_out};
    end
    assign aux_serial_in = slow ? dly_q[3] : dly_q[0];
endmodule
`default_nettype wire

// [dv/txs_top_test.sv]
// Self-checking bench for the driver and switch block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module txs_top_test;
    typedef struct packed {
        logic [7:0] ctl, mode;
        logic env, ka, kb, x;
        logic [5:0] pa, pb;
        logic [3:0] na, nb;
    } txs_row_t;
    localparam logic [19:0] CW = {6'h15, 6'h15, 4'hc, 4'hc};
    localparam logic [19:0] MD = {6'h2a, 6'h2a, 4'h3, 4'h3};
    localparam logic [19:0] BC = {6'h2a, 6'h15, 4'h3, 4'hc};
    localparam logic [7:0] RSTV [7] = '{8'h00, 8'h00, 8'h10, 8'h80, 8'h20, 8'h20, 8'h88};
    localparam logic [23:0] DSEL = {6'h15, 6'h15, 6'h2a, 6'h15};
    localparam logic [8:0] AUXE = 9'b011101110;
    localparam logic [3:0] RXE = 4'b1100;
    txs_row_t rows [10] = '{{8'h03, 8'h00, 4'b1110, CW}, {8'h03, 8'h00, 4'b0110, MD},
        {8'h43, 8'h00, 4'b0111, MD}, {8'h53, 8'h00, 4'b1111, CW},
        {8'h13, 8'h01, 4'b1111, CW}, {8'h03, 8'h01, 4'b0000, MD},
        {8'h07, 8'h01, 4'b0010, BC}, {8'h07, 8'h00, 4'b0110, BC},
        {8'h0b, 8'h01, 4'b0000, MD}, {8'h47, 8'h01, 4'b1111, CW}};
    logic ref_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, envelope = 1'b1;
    logic tx_serial = 1'b0, miller_tx = 1'b0, rx_analog = 1'b0, reply = 1'b0, slow = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, scratch;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, aux_serial_in, antenna_drive_a, antenna_drive_b;
    logic aux_serial_out, decoder_in, tx_bit_strobe;
    logic [5:0] pmos_array_setting_a, pmos_array_setting_b;
    logic [3:0] nmos_array_setting_a, nmos_array_setting_b;
    int mismatches = 0, n_tests = 0, i, n;
    assign hready = hreadyout;
    always #5 ref_clk = ~ref_clk;
    txs_top dut_u (.ref_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata, .envelope, .tx_serial, .miller_tx, .rx_analog,
        .aux_serial_in, .antenna_drive_a, .antenna_drive_b, .pmos_array_setting_a,
        .pmos_array_setting_b, .nmos_array_setting_a, .nmos_array_setting_b, .aux_serial_out,
        .decoder_in, .tx_bit_strobe);
    txs_ant_model ant_u (.ref_clk, .aux_serial_out, .reply, .slow, .aux_serial_in);
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        if (k >= 100) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [2:0] sz, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= w;
        hsize <= sz;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 3'h2, q);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 3'h2, q);
        `CHK(q, e)
        `CHK(hresp, 1'b0)
    endtask
    task automatic settle;
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic done(input string s);
        $display("test %s finished, %0d checks so far", s, n_tests);
    endtask
    task automatic row_chk(input txs_row_t r);
        logic a0, b0, a1, b1;
        wr(12'h000, {24'h0, r.ctl});
        wr(12'h004, {24'h0, r.mode});
        envelope <= r.env;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        a0 = antenna_drive_a;
        b0 = antenna_drive_b;
        @(negedge ref_clk);
        a1 = antenna_drive_a;
        b1 = antenna_drive_b;
        `CHK({a0 ^ a1, (a0 | a1) & ~r.ka}, {r.ka, 1'b0})
        `CHK({b0 ^ b1, (b0 | b1) & ~r.kb}, {r.kb, 1'b0})
        `CHK((a0 ^ b0) & r.ka & r.kb, r.x)
        `CHK({pmos_array_setting_a, pmos_array_setting_b, nmos_array_setting_a,
            nmos_array_setting_b}, {r.pa, r.pb, r.na, r.nb})
        @(posedge ref_clk);
    endtask
    task automatic next_strobe(output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (tx_bit_strobe !== 1'b1 && k < 600);
    endtask
    initial begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        for (i = 0; i < 7; i++) begin
            rd_chk(12'(4 * i), {24'h0, RSTV[i]});
        end
        rd_chk(12'h020, 32'h0);
        done("reset values");
        wr(12'h010, 32'h15);
        wr(12'h014, 32'h2a);
        wr(12'h018, 32'h3c);
        for (i = 0; i < 10; i++) begin
            row_chk(rows[i]);
        end
        done("driver table");
        // Narrow writes must not disturb a conductance register
        bus(1'b1, 12'h010, 32'h3f, 3'h0, scratch);
        rd_chk(12'h010, 32'h15);
        done("narrow write");
        for (i = 0; i < 5; i++) begin
            wr(12'h004, {25'h0, (i == 4) ? 3'h7 : 3'(i), 4'h0});
            next_strobe(n);
            next_strobe(n);
            next_strobe(n);
            `CHK(n, 256 >> ((i == 4) ? 3 : i))
        end
        done("bit rate");
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h03);
        envelope <= 1'b0;
        reply <= 1'b1;
        for (i = 0; i < 4; i++) begin
            wr(12'h008, {26'h0, 2'(i), 4'h0});
            settle();
            `CHK(pmos_array_setting_a, DSEL[i * 6 +: 6])
        end
        reply <= 1'b0;
        wr(12'h008, 32'h20);
        settle();
        `CHK(pmos_array_setting_a, 6'h2a)
        done("driver input select");
        wr(12'h000, 32'h0); // Passive drivers off while the active antenna runs
        tx_serial <= 1'b1;
        envelope <= 1'b1;
        reply <= 1'b1;
        slow <= 1'b1;
        rx_analog <= 1'b1;
        for (i = 0; i < 9; i++) begin
            wr(12'h008, {26'h0, 2'b01, 4'(i)});
            settle();
            `CHK(aux_serial_out, AUXE[i])
        end
        miller_tx <= 1'b1;
        wr(12'h008, 32'h14);
        settle();
        `CHK(aux_serial_out, 1'b1)
        // Quiet aux input so that code 01 differs from the analog taps
        miller_tx <= 1'b0;
        reply <= 1'b0;
        for (i = 0; i < 4; i++) begin
            wr(12'h00c, {24'h0, 2'(i), 6'h0});
            settle();
            `CHK(decoder_in, RXE[i])
        end
        // Active antenna loop: Miller out, back in through the aux input
        wr(12'h00c, 32'h40);
        miller_tx <= 1'b1;
        settle();
        `CHK(decoder_in, 1'b1)
        miller_tx <= 1'b0;
        settle();
        `CHK(decoder_in, 1'b0)
        rd_chk(12'h01c, 32'h31);
        done("aux routing");
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd_chk(12'h008, 32'h10);
        rd_chk(12'h00c, 32'h80);
        done("mid-run reset");
        tally_and_finish();
    end
endmodule
`default_nettype wire
